// ==== src/sffs_map.vh ====
`ifndef SFFS_MAP_VH
`define SFFS_MAP_VH
`define SFFS_CFG_ADDR 8'h11
`define SFFS_CFG_RESET 16'h5000
`define SFFS_CFG_WMASK 16'h3ffd
`define SFFS_A_EN_BIT 0
`define SFFS_A_FMT_LO 2
`define SFFS_B_EN_BIT 5
`define SFFS_B_FMT_LO 6
`define SFFS_GUARD_BIT 12
`define SFFS_FMT_NONE 3'h0
`define SFFS_FMT_SUM16 3'h1
`define SFFS_FMT_SUM32 3'h2
`define SFFS_FMT_CH16 3'h4
`define SFFS_FMT_CH32 3'h6
`endif

// ==== src/sffs_slot_fifo_format_select.v ====
`timescale 1ns/1ps
`include "sffs_map.vh"

// How it works
// R1: slot B format bits 8:6, zero pushes nothing
// R2: codes 1/2 push 16/32-bit four-channel sum
// R3: codes 4/6 push four 16/32-bit channel words
// R4: host keeps averaging equal before enabling B
// R5: slot B measures only when bit 5 set
// R6: slot A format bits 4:2, zero pushes nothing
// R7: slot A measures only when bit 0 set
// R8: guard 0 overwrites oldest, 1 drops when full
// R9: reserved codes 3,5,7 push nothing
module sffs_slot_fifo_format_select #(
    parameter DEPTH = 32,
    parameter AW = 5
) (
    // clock and reset
    input wire sys_clk_in,
    input wire rst_in,
    // register port
    input wire reg_wr_in,
    input wire [7:0] reg_addr_in,
    input wire [15:0] reg_wdata_in,
    output reg [15:0] reg_rdata_out,
    // sample inputs: one pulse per finished slot, four channels of 32 bits
    input wire slot_a_done_in,
    input wire slot_b_done_in,
    input wire [127:0] slot_a_data_in,
    input wire [127:0] slot_b_data_in,
    // fifo read side, 16-bit words
    input wire fifo_rd_in,
    output reg [15:0] fifo_data_out,
    output reg [AW:0] fifo_count_out,
    // slot measurement enables
    output reg slot_a_active_out,
    output reg slot_b_active_out
);
    // count that marks a full fifo, at the width of the counter
    localparam [AW:0] FULL_COUNT = DEPTH;
    localparam [AW:0] ZERO_COUNT = {(AW+1){1'b0}};
    localparam [AW-1:0] PTR_STEP = {{(AW-1){1'b0}}, 1'b1};
    localparam [3:0] NO_WORDS = 4'h0;

    // configuration register
    reg [15:0] cfg_r;
    reg [15:0] cfg_nxt;

    // fifo storage, pointers and fill count
    reg [15:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] wp_nxt;
    reg [AW-1:0] rp_r;
    reg [AW-1:0] rp_nxt;
    reg [AW:0] cnt_r;
    reg [AW:0] cnt_nxt;

    // serializer: up to eight words staged, lowest word first
    reg [127:0] stage_r;
    reg [127:0] stage_nxt;
    reg [3:0] left_r;
    reg [3:0] left_nxt;

    // one-deep hold for slot b while slot a or the serializer is busy
    reg pend_b_r;
    reg pend_b_nxt;
    reg [127:0] pend_b_data_r;
    reg [127:0] pend_b_data_nxt;

    // configuration fields
    wire [2:0] fmt_a = cfg_r[`SFFS_A_FMT_LO+2:`SFFS_A_FMT_LO];
    wire [2:0] fmt_b = cfg_r[`SFFS_B_FMT_LO+2:`SFFS_B_FMT_LO];
    wire en_a = cfg_r[`SFFS_A_EN_BIT];
    wire en_b = cfg_r[`SFFS_B_EN_BIT];
    wire guard = cfg_r[`SFFS_GUARD_BIT];
    wire cfg_hit = reg_addr_in == `SFFS_CFG_ADDR;

    // pack a slot's data per format into stage and word count
    function [131:0] pack;
        input [2:0] fmt;
        input [127:0] d;
        reg [31:0] sum;
        begin
            // sum wraps modulo 2^32
            sum = d[31:0] + d[63:32] + d[95:64] + d[127:96];
            case (fmt)
                `SFFS_FMT_SUM16: pack = {4'h1, 112'h0, sum[15:0]}; // [R2]
                `SFFS_FMT_SUM32: pack = {4'h2, 96'h0, sum}; // [R2]
                `SFFS_FMT_CH16: pack = {4'h4, 64'h0, d[111:96], d[79:64], d[47:32],
                    d[15:0]}; // [R3]
                `SFFS_FMT_CH32: pack = {4'h8, d}; // [R3]
                default: pack = 132'h0; // [R1] [R6] [R9]
            endcase
        end
    endfunction

    // a fresh slot b sample takes precedence over the held one
    wire [127:0] b_src = slot_b_done_in ? slot_b_data_in : pend_b_data_r;
    wire [131:0] pk_a = pack(fmt_a, slot_a_data_in);
    wire [131:0] pk_b = pack(fmt_b, b_src);

    // arbitration between the two slots
    wire idle = left_r == NO_WORDS;
    wire a_take = slot_a_done_in && en_a; // [R7]
    wire b_take = slot_b_done_in && en_b; // [R5]
    wire a_go = a_take && idle;
    wire b_req = b_take || pend_b_r;
    wire b_go = b_req && !a_go && idle;

    // fifo write and read qualification
    wire full = cnt_r == FULL_COUNT;
    wire empty = cnt_r == ZERO_COUNT;
    wire rd = fifo_rd_in && !empty;
    wire emit = !idle;
    wire wr = emit && (!full || !guard || rd); // [R8]
    wire drop_old = emit && full && !guard && !rd; // [R8]
    wire adv_rp = rd || drop_old;

    // bit 1 and bits 15:14 keep their fixed values
    always @* begin
        cfg_nxt = cfg_r;
        if (reg_wr_in && cfg_hit) begin
            cfg_nxt = (reg_wdata_in & `SFFS_CFG_WMASK) | (`SFFS_CFG_RESET & ~`SFFS_CFG_WMASK);
        end
    end

    // a second slot b sample while one is held replaces its data
    always @* begin
        pend_b_nxt = pend_b_r;
        pend_b_data_nxt = pend_b_data_r;
        if (b_go) begin
            pend_b_nxt = 1'b0;
        end else if (b_take) begin
            pend_b_nxt = 1'b1;
            pend_b_data_nxt = slot_b_data_in;
        end
    end

    // slot a wins; a busy serializer drops slot a samples
    always @* begin
        stage_nxt = stage_r;
        left_nxt = left_r;
        if (a_go) begin
            stage_nxt = pk_a[127:0];
            left_nxt = pk_a[131:128];
        end else if (b_go) begin
            stage_nxt = pk_b[127:0];
            left_nxt = pk_b[131:128];
        end else if (emit) begin
            stage_nxt = {16'h0, stage_r[127:16]};
            left_nxt = left_r - 4'h1;
        end
    end

    // pointers wrap at the depth; count tracks words held
    always @* begin
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        if (wr) begin
            wp_nxt = wp_r + PTR_STEP;
        end
        if (adv_rp) begin
            rp_nxt = rp_r + PTR_STEP;
        end
        cnt_nxt = cnt_r + {{AW{1'b0}}, wr} - {{AW{1'b0}}, adv_rp};
    end

    // configuration and serializer state
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            cfg_r <= `SFFS_CFG_RESET;
            pend_b_r <= 1'b0;
            pend_b_data_r <= 128'h0;
            stage_r <= 128'h0;
            left_r <= NO_WORDS;
        end else begin
            cfg_r <= cfg_nxt;
            pend_b_r <= pend_b_nxt;
            pend_b_data_r <= pend_b_data_nxt;
            stage_r <= stage_nxt;
            left_r <= left_nxt;
        end
    end

    // fifo pointers and count
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            wp_r <= {AW{1'b0}};
            rp_r <= {AW{1'b0}};
            cnt_r <= ZERO_COUNT;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // storage has no reset: only words written are ever read
    always @(posedge sys_clk_in) begin
        if (!rst_in && wr) begin
            mem_r[wp_r] <= stage_r[15:0];
        end
    end

    // registered outputs
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 16'h0;
            fifo_data_out <= 16'h0;
            fifo_count_out <= ZERO_COUNT;
            slot_a_active_out <= 1'b0;
            slot_b_active_out <= 1'b0;
        end else begin
            reg_rdata_out <= cfg_hit ? cfg_r : 16'h0;
            slot_a_active_out <= en_a; // [R7]
            slot_b_active_out <= en_b; // [R5]
            if (rd) begin
                fifo_data_out <= mem_r[rp_r];
            end
            fifo_count_out <= cnt_nxt;
        end
    end
endmodule // sffs_slot_fifo_format_select

// ==== test/sffs_host_model.sv ====
`timescale 1ns/1ps
module sffs_host_model (
    input wire clk_in,
    input wire [5:0] count_in,
    output reg rd_out
);
    initial rd_out = 1'b0;
    // pops every other cycle, never when empty
    always @(posedge clk_in) rd_out <= count_in != 6'h0 && !rd_out;
endmodule // sffs_host_model

// ==== test/sffs_chk.sv ====
`timescale 1ns/1ps
module sffs_chk #(parameter AW = 5) (
    // watched ports
    input wire sys_clk_in,
    input wire rst_in,
    input wire reg_wr_in,
    input wire [7:0] reg_addr_in,
    input wire [15:0] reg_wdata_in,
    input wire [15:0] reg_rdata_out,
    input wire slot_a_done_in,
    input wire slot_b_done_in,
    input wire fifo_rd_in,
    input wire [AW:0] fifo_count_out,
    input wire slot_a_active_out,
    input wire slot_b_active_out
);
    wire quiet = !slot_a_done_in && !slot_b_done_in;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    sequence cfg_wr; reg_wr_in && reg_addr_in == 8'h11 ##1 !reg_wr_in; endsequence
    sequence idle16; quiet [*8] ##1 quiet [*8]; endsequence
    a_count_bound: assert property (fifo_count_out <= 32)
        else $error("fifo count above depth");
    a_count_rise: assert property (fifo_count_out <= $past(fifo_count_out) + 1)
        else $error("fifo count rose by more than one");
    a_cfg_read: assert property (cfg_wr ##0 reg_addr_in == 8'h11 |=>
        reg_rdata_out == (($past(reg_wdata_in, 2) & 16'h3ffd) | 16'h4000)) else $error("bad readback");
    a_a_enable: assert property (cfg_wr |=> slot_a_active_out == $past(reg_wdata_in[0], 2))
        else $error("slot a enable mismatch");
    a_b_enable: assert property (cfg_wr |=> slot_b_active_out == $past(reg_wdata_in[5], 2))
        else $error("slot b enable mismatch");
    a_pop_no_grow: assert property (fifo_rd_in && fifo_count_out != 0 |=>
        fifo_count_out <= $past(fifo_count_out)) else $error("count grew on pop");
    a_idle_hold: assert property (idle16 |=> fifo_count_out <= $past(fifo_count_out))
        else $error("words without a sample");
    a_idle_pop: assert property (idle16 ##0 fifo_rd_in && fifo_count_out != 0 |=>
        fifo_count_out == $past(fifo_count_out) - 1) else $error("pop not counted");
endmodule // sffs_chk
bind sffs_slot_fifo_format_select sffs_chk #(.AW(AW)) chk_u (.*);

// ==== test/tb.sv ====
`timescale 1ns/1ps
module tb;
    reg sys_clk_in = 0, rst_in = 1, wr = 0, da = 0, db = 0, rd_d = 0;
    reg [15:0] wd = 16'h0;
    reg [127:0] d = 128'h0;
    reg [31:0] w;
    reg [15:0] exq[$];
    wire [15:0] rdata, q;
    wire [5:0] cnt;
    wire rd;
    integer n_errors = 0, tests_run = 0, seed = 14082, s, c, i;
    always #20 sys_clk_in = ~sys_clk_in;
    sffs_slot_fifo_format_select dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_wr_in(wr),
        .reg_addr_in(8'h11), .reg_wdata_in(wd), .reg_rdata_out(rdata), .slot_a_done_in(da),
        .slot_b_done_in(db), .slot_a_data_in(d), .slot_b_data_in(d), .fifo_rd_in(rd),
        .fifo_data_out(q), .fifo_count_out(cnt), .slot_a_active_out(), .slot_b_active_out());
    sffs_host_model host_u (.clk_in(sys_clk_in), .count_in(cnt), .rd_out(rd));
    task chk(input string n, input [15:0] e, input [15:0] g);
        tests_run++;
        if (e !== g) begin
            n_errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task stop_test;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge sys_clk_in) rd_d <= rd;
    always @(negedge sys_clk_in) if (rd_d) chk("fifo", exq.size() ? exq.pop_front() : 16'hdead, q);
    initial begin
        #100000;
        n_errors++;
        stop_test;
    end
    initial begin
        repeat (5) @(posedge sys_clk_in);
        rst_in <= 0;
        repeat (2) @(posedge sys_clk_in);
        chk("cfg", 16'h5000, rdata);
        for (s = 0; s < 3; s++) for (c = 0; c < 8; c++) begin
            d <= {$random(seed), $random(seed), $random(seed), $random(seed)};
            wd <= s == 0 ? c << 2 | 1 : s == 1 ? c << 6 | 32 : c << 2;
            wr <= 1;
            @(posedge sys_clk_in);
            wr <= 0;
            repeat (2) @(posedge sys_clk_in);
            chk("cfg", wd | 16'h4000, rdata);
            if (s == 1) db <= 1; else da <= 1;
            @(posedge sys_clk_in);
            da <= 0;
            db <= 0;
            w = d[31:0] + d[63:32] + d[95:64] + d[127:96];
            if (s < 2 && (c == 1 || c == 2)) exq.push_back(w[15:0]);
            if (s < 2 && c == 2) exq.push_back(w[31:16]);
            for (i = 0; i < 4; i++) if (s < 2 && (c == 4 || c == 6)) begin
                exq.push_back(d[32*i+:16]);
                if (c == 6) exq.push_back(d[32*i+16+:16]);
            end
            repeat (30) @(posedge sys_clk_in);
        end
        chk("left", 16'h0, exq.size());
        stop_test;
    end
endmodule // tb
